// file: vic_pkg.sv
// How it works
// [R1] Enabled channel event sets its pending bit.
// [R2] Vectored acknowledge clears the winning pending bit.
// [R3] Polled host reads pending, clears it itself.
// [R4] Pending write: zeros clear, ones keep.
// [R5] Disabling a channel clears its pending bit.
// [R6] Masked channel still pends, never requests.
// [R7] Clearing mask withdraws that channel's request.
// [R8] Re-set mask resumes service by priority.
// [R9] Mask and in-service reads have no side effects.
// [R10] End-of-interrupt is an in-service write and acts outside acknowledge cycles too.
// [R11] Vector S bit selects software end-of-interrupt.
// [R12] Automatic mode forces in-service bits to zero.
// [R13] Software mode acknowledge sets in-service, clears pending.
// [R14] In-service blocks lower channels, not higher.
// [R15] In-service channel pends but cannot re-request.
// [R16] In-service write: zeros clear, never set.
// [R17] Host lowers own mask to nest requests.
// [R18] Eight port lines, each input or output.
// [R19] Port lines interrupt on selected edge.
// [R20] Output lines drive data bits; inputs float.
// [R21] Port read: outputs from register, inputs live.
// [R22] Vector is upper nibble plus channel number.
// [R23] Request output follows pending, enable, mask, blocking.
`default_nettype none
package vic_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned NCHAN = 16;
  // Register addresses, one register per address.
  localparam logic [4:0] ADDR_GENERAL_PORT = 5'h01;
  localparam logic [4:0] ADDR_EDGE_SEL = 5'h03;
  localparam logic [4:0] ADDR_DIRECTION = 5'h05;
  localparam logic [4:0] ADDR_CHAN_ENABLE_A = 5'h07;
  localparam logic [4:0] ADDR_CHAN_ENABLE_B = 5'h09;
  localparam logic [4:0] ADDR_PENDING_A = 5'h0B;
  localparam logic [4:0] ADDR_PENDING_B = 5'h0D;
  localparam logic [4:0] ADDR_INSERVICE_A = 5'h0F;
  localparam logic [4:0] ADDR_INSERVICE_B = 5'h11;
  localparam logic [4:0] ADDR_MASK_A = 5'h13;
  localparam logic [4:0] ADDR_MASK_B = 5'h15;
  localparam logic [4:0] ADDR_VECTOR = 5'h17;
  // Vector register layout.
  localparam int unsigned VEC_S_BIT = 3;
  localparam logic [7:0] VEC_WRITE_MASK = 8'hF8;
  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // Channel number of each port line, lowest line first.
  localparam logic [31:0] PORT_CHAN_MAP = 32'hFE76_3210;

  // One register bus access.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } vic_bus_t;

  // Acknowledge answer to the host.
  typedef struct packed {
    logic valid;
    logic none;
    logic [7:0] vector;
  } vic_ack_t;
endpackage : vic_pkg
`default_nettype wire

// file: vic_core.sv
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module vic_core #(
  parameter int unsigned NCHAN = 16
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Register port.
  input wire vic_pkg::vic_bus_t bus_i,
  output logic [7:0] rd_data_o,
  // Interrupt sources other than the port lines.
  input wire logic [NCHAN-1:0] chan_event_i,
  // Host acknowledge.
  input wire logic iack_i,
  output vic_pkg::vic_ack_t ack_o,
  output logic irq_o,
  // General port pins.
  input wire logic [7:0] port_in_i,
  output logic [7:0] port_out_o,
  output logic [7:0] port_oe_o
);

  // Highest set bit of a channel vector.
  function automatic logic [3:0] top_chan(input logic [NCHAN-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < NCHAN; i++) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // Channels blocked by an in-service bit at equal or higher priority.
  function automatic logic [NCHAN-1:0] blocked(input logic [NCHAN-1:0] isr);
    logic [NCHAN-1:0] b;
    logic acc;
    b = '0;
    acc = 1'b0;
    for (int i = NCHAN - 1; i >= 0; i--) begin
      acc = acc | isr[i];
      b[i] = acc;
    end
    return b;
  endfunction

  logic [7:0] port_data;
  logic [7:0] edge_sel;
  logic [7:0] direction;
  logic [NCHAN-1:0] enable;
  logic [NCHAN-1:0] pending;
  logic [NCHAN-1:0] inservice;
  logic [NCHAN-1:0] mask;
  logic [7:0] vec_reg;
  logic [7:0] port_lvl_q;
  logic [7:0] port_lvl;
  logic [NCHAN-1:0] port_evt;
  logic [NCHAN-1:0] event_set;
  logic [NCHAN-1:0] request;
  logic [NCHAN-1:0] ack_clr;
  logic [NCHAN-1:0] wr_pend_clr;
  logic [NCHAN-1:0] wr_en_clr;
  logic [NCHAN-1:0] wr_isr_clr;
  logic [NCHAN-1:0] next_pending;
  logic [NCHAN-1:0] next_inservice;
  logic [NCHAN-1:0] next_enable;
  logic [3:0] win_chan;
  logic soft_eoi;
  logic wr_en_a;
  logic wr_en_b;
  logic [7:0] next_rd;

  assign soft_eoi = vec_reg[vic_pkg::VEC_S_BIT]; // [R11]
  assign wr_en_a = bus_i.wr && (bus_i.addr == vic_pkg::ADDR_CHAN_ENABLE_A);
  assign wr_en_b = bus_i.wr && (bus_i.addr == vic_pkg::ADDR_CHAN_ENABLE_B);

  // The edge detector compares the line with its edge bit, so rewriting the
  // edge bit can itself raise an event; software sets edges before enabling.
  assign port_lvl = ~(port_in_i ^ edge_sel); // [R19]
  always_comb begin
    port_evt = '0;
    for (int i = 0; i < 8; i++) begin
      port_evt[vic_pkg::PORT_CHAN_MAP[4*i +: 4]] = port_lvl[i] & ~port_lvl_q[i];
    end
  end

  // Port channels take their events from the pins, the rest from the sources.
  always_comb begin
    event_set = chan_event_i;
    for (int i = 0; i < 8; i++) begin
      event_set[vic_pkg::PORT_CHAN_MAP[4*i +: 4]] = port_evt[vic_pkg::PORT_CHAN_MAP[4*i +: 4]];
    end
  end

  // Request terms: masked and blocked channels keep pending but stay quiet.
  assign request = pending & enable & mask & ~blocked(inservice); // [R6] [R7] [R14] [R15]
  assign win_chan = top_chan(request); // [R8]

  // The acknowledge clears only the channel whose vector is passed.
  always_comb begin
    ack_clr = '0;
    if (iack_i && (request != '0)) begin
      ack_clr[win_chan] = 1'b1; // [R2]
    end
  end

  // Byte-wide write decode for the paired registers.
  always_comb begin
    next_enable = enable;
    if (wr_en_a) begin
      next_enable[15:8] = bus_i.wdata;
    end
    if (wr_en_b) begin
      next_enable[7:0] = bus_i.wdata;
    end
    wr_en_clr = enable & ~next_enable; // [R5]
    wr_pend_clr = '0;
    wr_isr_clr = '0;
    if (bus_i.wr) begin
      case (bus_i.addr)
        vic_pkg::ADDR_PENDING_A: wr_pend_clr[15:8] = ~bus_i.wdata; // [R4]
        vic_pkg::ADDR_PENDING_B: wr_pend_clr[7:0] = ~bus_i.wdata; // [R4]
        vic_pkg::ADDR_INSERVICE_A: wr_isr_clr[15:8] = ~bus_i.wdata; // [R16]
        vic_pkg::ADDR_INSERVICE_B: wr_isr_clr[7:0] = ~bus_i.wdata; // [R16]
        default: wr_isr_clr = '0;
      endcase
    end
  end

  // A new event wins over any clear in the same cycle; a channel being
  // disabled in that cycle counts as disabled.
  assign next_pending = (pending & ~(ack_clr | wr_pend_clr | wr_en_clr))
                        | (event_set & next_enable); // [R1] [R15]

  // In-service bits exist only in software mode and only software clears them.
  assign next_inservice = soft_eoi
                          ? ((inservice & ~wr_isr_clr) | ack_clr) // [R13] [R10]
                          : '0; // [R12]

  // Channel state.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pending <= vic_pkg::RST_WORD;
      inservice <= vic_pkg::RST_WORD;
      enable <= vic_pkg::RST_WORD;
    end else begin
      pending <= next_pending;
      inservice <= next_inservice;
      enable <= next_enable;
    end
  end

  // Plain software registers.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      port_data <= vic_pkg::RST_BYTE;
      edge_sel <= vic_pkg::RST_BYTE;
      direction <= vic_pkg::RST_BYTE;
      mask <= vic_pkg::RST_WORD;
      vec_reg <= vic_pkg::RST_BYTE;
    end else if (bus_i.wr) begin
      case (bus_i.addr)
        vic_pkg::ADDR_GENERAL_PORT: port_data <= bus_i.wdata; // [R18]
        vic_pkg::ADDR_EDGE_SEL: edge_sel <= bus_i.wdata;
        vic_pkg::ADDR_DIRECTION: direction <= bus_i.wdata; // [R18]
        vic_pkg::ADDR_MASK_A: mask[15:8] <= bus_i.wdata;
        vic_pkg::ADDR_MASK_B: mask[7:0] <= bus_i.wdata;
        vic_pkg::ADDR_VECTOR: vec_reg <= bus_i.wdata & vic_pkg::VEC_WRITE_MASK;
        default: vec_reg <= vec_reg;
      endcase
    end
  end

  // Previous detector level, for edge finding.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      port_lvl_q <= vic_pkg::RST_BYTE;
    end else begin
      port_lvl_q <= port_lvl;
    end
  end

  // Pin drive: outputs show their data bit, inputs are released.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      port_out_o <= vic_pkg::RST_BYTE;
      port_oe_o <= vic_pkg::RST_BYTE;
    end else begin
      port_out_o <= port_data & direction; // [R20]
      port_oe_o <= direction; // [R20]
    end
  end

  // Read mux; reads never change state.
  always_comb begin
    case (bus_i.addr)
      vic_pkg::ADDR_GENERAL_PORT: next_rd = (port_data & direction)
                                            | (port_in_i & ~direction); // [R21]
      vic_pkg::ADDR_EDGE_SEL: next_rd = edge_sel;
      vic_pkg::ADDR_DIRECTION: next_rd = direction;
      vic_pkg::ADDR_CHAN_ENABLE_A: next_rd = enable[15:8];
      vic_pkg::ADDR_CHAN_ENABLE_B: next_rd = enable[7:0];
      vic_pkg::ADDR_PENDING_A: next_rd = pending[15:8]; // [R3]
      vic_pkg::ADDR_PENDING_B: next_rd = pending[7:0]; // [R3]
      vic_pkg::ADDR_INSERVICE_A: next_rd = inservice[15:8]; // [R9]
      vic_pkg::ADDR_INSERVICE_B: next_rd = inservice[7:0]; // [R9]
      vic_pkg::ADDR_MASK_A: next_rd = mask[15:8]; // [R9]
      vic_pkg::ADDR_MASK_B: next_rd = mask[7:0]; // [R9]
      vic_pkg::ADDR_VECTOR: next_rd = vec_reg;
      default: next_rd = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= vic_pkg::RST_BYTE;
    end else if (bus_i.rd) begin
      rd_data_o <= next_rd;
    end else begin
      rd_data_o <= vic_pkg::RST_BYTE;
    end
  end

  // Request output is re-evaluated every clock, so a cleared mask drops it.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (next_pending & next_enable & mask & ~blocked(next_inservice)) != '0; // [R23]
    end
  end

  // Acknowledge answer, one cycle after the strobe, for one cycle.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= '0;
    end else begin
      ack_o.valid <= iack_i && (request != '0);
      ack_o.none <= iack_i && (request == '0);
      ack_o.vector <= (iack_i && (request != '0)) ? {vec_reg[7:4], win_chan} : 8'h00; // [R22]
    end
  end

  // Checks.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_event_sets_pend: assert property ( // [R1]
    (event_set[5] && next_enable[5]) |=> pending[5])
    else $error("Enabled event did not set pending.");

  a_ack_clears_pend: assert property ( // [R2]
    (iack_i && request[win_chan] && !event_set[win_chan])
    |=> !pending[$past(win_chan)])
    else $error("Acknowledged channel still pending.");

  a_write_zero_pend: assert property ( // [R4]
    (bus_i.wr && bus_i.addr == vic_pkg::ADDR_PENDING_B && !bus_i.wdata[0] && !event_set[0])
    |=> !pending[0])
    else $error("Pending bit written zero survived.");

  a_write_one_keeps: assert property ( // [R4]
    (bus_i.wr && bus_i.addr == vic_pkg::ADDR_PENDING_B && bus_i.wdata == 8'hFF && !iack_i
     && !wr_en_clr[0] && pending[0]) |=> pending[0])
    else $error("Pending bit written one changed.");

  a_disable_clears: assert property ( // [R5]
    (wr_en_b && enable[5] && !bus_i.wdata[5]) |=> !pending[5])
    else $error("Disabled channel kept pending.");

  a_masked_quiet: assert property ( // [R6] [R7]
    (mask == '0) |=> !irq_o)
    else $error("Request raised while all masked.");

  a_auto_isr_zero: assert property ( // [R12]
    !soft_eoi |=> (inservice == '0) || $past(bus_i.wr))
    else $error("In-service bits set in automatic mode.");

  a_soft_sets_isr: assert property ( // [R13]
    (soft_eoi && iack_i && request != '0 && !bus_i.wr)
    |=> inservice[$past(win_chan)] && ack_o.valid)
    else $error("Software mode acknowledge missed in-service.");

  a_isr_blocks_low: assert property ( // [R14]
    inservice[9] |-> (request[8:0] == '0))
    else $error("Lower channel requested under in-service.");

  a_isr_no_set: assert property ( // [R16]
    (!iack_i) |=> ((inservice & ~$past(inservice)) == '0))
    else $error("In-service bit set without acknowledge.");

  a_vector_form: assert property ( // [R22]
    ack_o.valid |-> (ack_o.vector[7:4] == $past(vec_reg[7:4])) && !ack_o.none)
    else $error("Vector upper nibble wrong.");

  a_port_drive: assert property ( // [R20]
    ##1 (port_oe_o == $past(direction)) && ((port_out_o & ~port_oe_o) == 8'h00))
    else $error("Port drive does not follow direction.");

  // The request output lags a mask write by one clock, so write cycles are left out.
  a_irq_tracks_req: assert property ( // [R23]
    (!bus_i.wr) |=> (irq_o == (request != '0)))
    else $error("Request output does not follow requesting channels.");

  a_read_no_effect: assert property ( // [R9]
    (bus_i.rd && !bus_i.wr && !iack_i && soft_eoi) |=> $stable(mask) && $stable(inservice))
    else $error("Register read changed mask or in-service bits.");

  a_mask_read: assert property ( // [R9]
    (bus_i.rd && bus_i.addr == vic_pkg::ADDR_MASK_B) |=> (rd_data_o == $past(mask[7:0])))
    else $error("Mask read returned wrong contents.");

  a_isr_write_zero: assert property ( // [R16]
    (bus_i.wr && bus_i.addr == vic_pkg::ADDR_INSERVICE_B && !bus_i.wdata[5] && !iack_i)
    |=> !inservice[5])
    else $error("In-service bit written zero survived.");

  a_vector_chan: assert property ( // [R22]
    (iack_i && request != '0) |=> ack_o.valid && (ack_o.vector[3:0] == $past(win_chan)))
    else $error("Vector channel field wrong.");

  a_pend_needs_en: assert property ( // [R5]
    (pending & ~enable) == '0)
    else $error("Pending bit set on a disabled channel.");

  a_high_not_blocked: assert property ( // [R14]
    (pending[9] && enable[9] && mask[9] && inservice[15:9] == '0) |-> request[9])
    else $error("Higher channel blocked by lower in-service bit.");

  a_none_when_idle: assert property ( // [R14]
    (iack_i && request == '0) |=> ack_o.none && !ack_o.valid)
    else $error("Vector passed with no channel requesting.");

  a_auto_ack_no_isr: assert property ( // [R12]
    (!soft_eoi && iack_i) |=> (inservice == '0))
    else $error("Automatic mode acknowledge left in-service bit.");

  a_port_edge: assert property ( // [R19]
    (port_lvl[0] && !port_lvl_q[0] && next_enable[0]) |=> pending[0])
    else $error("Port line edge did not set pending.");

endmodule // vic_core
`default_nettype wire

// file: vic_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module vic_host_model (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Request from the bench and the answer handed back.
  input wire logic go_i,
  output logic done_o,
  output logic none_o,
  output logic [7:0] vec_o,
  // Device side.
  output logic iack_o,
  input wire vic_pkg::vic_ack_t ack_i
);
  // One acknowledge per request; the answer is captured when the device gives it.
  // A nesting host lowers its own mask, so back-to-back requests are allowed.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      iack_o <= 1'b0;
      done_o <= 1'b0;
      none_o <= 1'b0;
      vec_o <= 8'h00;
    end else begin
      iack_o <= go_i;
      done_o <= ack_i.valid | ack_i.none;
      if (ack_i.valid | ack_i.none) begin
        none_o <= ack_i.none;
        vec_o <= ack_i.vector;
      end
    end
  end
endmodule // vic_host_model
`default_nettype wire

// file: tb_vic_core.sv
`timescale 1ns/1ns
`default_nettype none
module tb_vic_core;
  logic clk_sys_i;
  logic rst_i;
  vic_pkg::vic_bus_t bus;
  logic [7:0] rd_data;
  logic [15:0] ev;
  logic iack;
  vic_pkg::vic_ack_t ack;
  logic irq;
  logic [7:0] pin;
  logic [7:0] pout;
  logic [7:0] poe;
  logic go;
  logic done;
  logic none;
  logic [7:0] vec;
  logic [7:0] dir;
  logic [7:0] data;
  int bad_count;
  int comparisons;

  vic_core #(.NCHAN(16)) vic_core_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_i(bus),
    .rd_data_o(rd_data), .chan_event_i(ev), .iack_i(iack), .ack_o(ack), .irq_o(irq),
    .port_in_i(pin), .port_out_o(pout), .port_oe_o(poe));
  vic_host_model vic_host_model_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .go_i(go),
    .done_o(done), .none_o(none), .vec_o(vec), .iack_o(iack), .ack_i(ack));

  // The 10 MHz system clock.
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task automatic end_sim;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Settle point one step after an edge, so that edge's updates have landed.
  task automatic tick;
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    bus <= '0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    bus <= '0;
    #1;
    check(rd_data, exp);
  endtask

  task automatic pulse(input int ch);
    @(posedge clk_sys_i);
    ev <= 16'h0001 << ch;
    @(posedge clk_sys_i);
    ev <= '0;
    tick();
  endtask

  // The wait is bounded so a silent device shows up as a mismatch, not a hang.
  task automatic ackc;
    @(posedge clk_sys_i);
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
    for (int i = 0; i < 8 && done !== 1'b1; i++) tick();
    check(done, 1'b1);
  endtask

  function automatic logic [7:0] vexp(input logic [7:0] base, input int ch);
    return {base[7:4], 4'(ch)};
  endfunction

  function automatic logic [7:0] pexp(input logic [7:0] d, input logic [7:0] r,
                                      input logic [7:0] p);
    return (d & r) | (p & ~r);
  endfunction

  // A hang is cut short well beyond the few hundred cycles the tests need.
  initial begin
    #(20000 * 100);
    bad_count++;
    $display("unexpected timeout at %0t", $time);
    end_sim();
  end

  initial begin
    bus = '0;
    ev = '0;
    pin = '0;
    go = 1'b0;
    rst_i = 1'b1;
    void'($urandom(32'hf360));
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rdchk(vic_pkg::ADDR_MASK_B, 8'h00);
    rdchk(vic_pkg::ADDR_INSERVICE_B, 8'h00);
    $display("test reset done");
    // Automatic end-of-interrupt on channel 5.
    wr(vic_pkg::ADDR_VECTOR, 8'h40);
    wr(vic_pkg::ADDR_CHAN_ENABLE_B, 8'h20);
    wr(vic_pkg::ADDR_MASK_B, 8'h20);
    pulse(5);
    check(irq, 1'b1);
    rdchk(vic_pkg::ADDR_PENDING_B, 8'h20);
    wr(vic_pkg::ADDR_MASK_B, 8'h00);
    tick();
    check(irq, 1'b0);
    pulse(5);
    check(irq, 1'b0);
    rdchk(vic_pkg::ADDR_PENDING_B, 8'h20);
    rdchk(vic_pkg::ADDR_MASK_B, 8'h00);
    wr(vic_pkg::ADDR_MASK_B, 8'h20);
    tick();
    check(irq, 1'b1);
    ackc();
    check(vec, vexp(8'h40, 5));
    rdchk(vic_pkg::ADDR_PENDING_B, 8'h00);
    rdchk(vic_pkg::ADDR_INSERVICE_B, 8'h00);
    $display("test automatic done");
    // Software end-of-interrupt with blocking by priority.
    wr(vic_pkg::ADDR_VECTOR, 8'h4F);
    rdchk(vic_pkg::ADDR_VECTOR, 8'h48);
    wr(vic_pkg::ADDR_CHAN_ENABLE_A, 8'h02);
    wr(vic_pkg::ADDR_MASK_A, 8'h02);
    pulse(5);
    ackc();
    check(vec, vexp(8'h40, 5));
    rdchk(vic_pkg::ADDR_INSERVICE_B, 8'h20);
    rdchk(vic_pkg::ADDR_PENDING_B, 8'h00);
    wr(vic_pkg::ADDR_CHAN_ENABLE_B, 8'h30);
    wr(vic_pkg::ADDR_MASK_B, 8'h30);
    pulse(4);
    pulse(5);
    check(irq, 1'b0);
    rdchk(vic_pkg::ADDR_PENDING_B, 8'h30);
    ackc();
    check(none, 1'b1);
    pulse(9);
    check(irq, 1'b1);
    ackc();
    check(vec, vexp(8'h40, 9));
    wr(vic_pkg::ADDR_INSERVICE_A, 8'hFF);
    rdchk(vic_pkg::ADDR_INSERVICE_A, 8'h02);
    wr(vic_pkg::ADDR_INSERVICE_A, 8'hFD);
    rdchk(vic_pkg::ADDR_INSERVICE_A, 8'h00);
    check(irq, 1'b0);
    wr(vic_pkg::ADDR_INSERVICE_B, 8'hDF);
    tick();
    check(irq, 1'b1);
    ackc();
    check(vec, vexp(8'h40, 5));
    wr(vic_pkg::ADDR_PENDING_B, 8'hFF);
    rdchk(vic_pkg::ADDR_PENDING_B, 8'h10);
    wr(vic_pkg::ADDR_PENDING_B, 8'hEF);
    rdchk(vic_pkg::ADDR_PENDING_B, 8'h00);
    pulse(5);
    wr(vic_pkg::ADDR_CHAN_ENABLE_B, 8'h10);
    rdchk(vic_pkg::ADDR_PENDING_B, 8'h00);
    wr(vic_pkg::ADDR_VECTOR, 8'h40);
    rdchk(vic_pkg::ADDR_INSERVICE_B, 8'h00);
    ackc();
    check(none, 1'b1);
    $display("test software done");
    // Port line 0 interrupts on a rising, then a falling edge select in software mode, then random port traffic.
    wr(vic_pkg::ADDR_VECTOR, 8'h48);
    wr(vic_pkg::ADDR_EDGE_SEL, 8'h01);
    wr(vic_pkg::ADDR_CHAN_ENABLE_B, 8'h01);
    wr(vic_pkg::ADDR_MASK_B, 8'h01);
    @(posedge clk_sys_i);
    pin <= 8'h01;
    repeat (3) tick();
    check(irq, 1'b1);
    rdchk(vic_pkg::ADDR_PENDING_B, 8'h01);
    // Polled service: software reads pending and clears it, with no acknowledge.
    wr(vic_pkg::ADDR_PENDING_B, 8'hFF);
    rdchk(vic_pkg::ADDR_PENDING_B, 8'h01);
    wr(vic_pkg::ADDR_PENDING_B, 8'hFE);
    rdchk(vic_pkg::ADDR_PENDING_B, 8'h00);
    check(irq, 1'b0);
    rdchk(vic_pkg::ADDR_INSERVICE_B, 8'h00);
    // Falling edge select on the same line.
    wr(vic_pkg::ADDR_EDGE_SEL, 8'h00);
    @(posedge clk_sys_i);
    pin <= 8'h00;
    repeat (3) tick();
    check(irq, 1'b1);
    rdchk(vic_pkg::ADDR_PENDING_B, 8'h01);
    wr(vic_pkg::ADDR_CHAN_ENABLE_B, 8'h00);
    for (int i = 0; i < 10; i++) begin
      dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      data = 8'($urandom);
      wr(vic_pkg::ADDR_DIRECTION, dir);
      wr(vic_pkg::ADDR_GENERAL_PORT, data);
      @(posedge clk_sys_i);
      pin <= 8'($urandom);
      tick();
      check(pout, data & dir);
      check(poe, dir);
      rdchk(vic_pkg::ADDR_GENERAL_PORT, pexp(data, dir, pin));
    end
    $display("test port done");
    end_sim();
  end
endmodule // tb_vic_core
`default_nettype wire
